//--- design/sgw_pkg.sv
// Package: register map, field layout, reset values and bus carriers
package sgw_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_WAKE_STATUS_MAIN       = 8'h00;
  localparam logic [7:0] IDX_WAKE_STATUS_PINS       = 8'h01;
  localparam logic [7:0] IDX_WAKE_ENABLE_MAIN       = 8'h02;
  localparam logic [7:0] IDX_WAKE_ENABLE_PINS       = 8'h03;
  localparam logic [7:0] IDX_WAKE_CONFIGURATION     = 8'h04;
  localparam logic [7:0] IDX_RSVD_LO_FIRST          = 8'h05;
  localparam logic [7:0] IDX_RSVD_LO_LAST           = 8'h07;
  localparam logic [7:0] IDX_STANDBY_BIDIR_OUT_LATCH = 8'h08;
  localparam logic [7:0] IDX_STANDBY_BIDIR_IN_LEVEL  = 8'h09;
  localparam logic [7:0] IDX_STANDBY_OUTONLY_LATCH   = 8'h0A;
  localparam logic [7:0] IDX_STANDBY_MIXED_IN_LEVEL  = 8'h0B;
  localparam logic [7:0] IDX_RSVD_HI_FIRST          = 8'h0C;
  localparam logic [7:0] IDX_RSVD_HI_LAST           = 8'h12;
  localparam logic [7:0] IDX_WAKE_CLEAR_MAIN        = 8'h20;
  localparam logic [7:0] IDX_WAKE_CLEAR_PINS        = 8'h21;
  localparam logic [7:0] IDX_PIN_CONFIG_LOCK        = 8'h22;
  localparam logic [7:0] IDX_PIN_OUTPUT_ENABLE      = 8'h23;
  localparam logic [7:0] IDX_PIN_PUSH_PULL          = 8'h24;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int NUM_BIDIR       = 6;
  localparam int NUM_OUTONLY     = 2;
  localparam int NUM_LOCK        = NUM_BIDIR + NUM_OUTONLY;
  localparam int CFG_PB_S3_BIT   = 3;
  localparam int CFG_SWAP_KBC_BIT = 2;
  localparam int CFG_BANK_MSB    = 1;
  localparam int CFG_BANK_LSB    = 0;
  localparam int CFG_WIDTH       = 4;
  localparam int LOCK_OUTONLY_LSB = NUM_BIDIR;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [NUM_BIDIR-1:0]   RST_BIDIR_LATCH   = 6'h3F;
  localparam logic [NUM_OUTONLY-1:0] RST_OUTONLY_LATCH = 2'h3;
  localparam logic [7:0]             RST_ZERO_BYTE     = 8'h00;
  localparam logic [31:0]            RD_ZERO           = 32'h0000_0000;

  // ************************************************************
  // APB carriers
  // ************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata;
  } sgw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sgw_apb_rsp_t;

endpackage

//--- design/sgw_standby_gpio_wake_regs.sv
// Standby pin data latches, live level readback and common wake registers
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module sgw_standby_gpio_wake_regs
  import sgw_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  // Clock and resets
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          main_reset,
  // APB slave
  input  wire sgw_pkg::sgw_apb_req_t         apb_req,
  output sgw_pkg::sgw_apb_rsp_t              apb_rsp,
  // Standby bidirectional pins
  input  wire logic [sgw_pkg::NUM_BIDIR-1:0] standby_bidir_pins_i,
  output logic [sgw_pkg::NUM_BIDIR-1:0]      standby_bidir_pins_o,
  output logic [sgw_pkg::NUM_BIDIR-1:0]      standby_bidir_pins_oe,
  // Standby output-only pins
  input  wire logic [1:0]                    standby_output_pins_i,
  output logic [1:0]                         standby_output_pins_o,
  output logic [1:0]                         standby_output_pins_oe,
  // Standby input-only pins
  input  wire logic [1:0]                    standby_input_pins_hi,
  input  wire logic [1:0]                    standby_input_pins_lo,
  // Wake sources
  input  wire logic [7:0]                    wake_event_main,
  input  wire logic [7:0]                    wake_event_pins,
  // Wake outputs
  output logic                               wake_irq,
  output logic                               power_button_s3_en,
  output logic                               swap_kbc_inputs,
  output logic [1:0]                         config_bank_sel
);
  import sgw_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ADDR_W != 10)
  begin : g_bad_addr
    $error("ADDR_W must be 10");
  end

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]             sts_main_ff,  nxt_sts_main;
  logic [7:0]             sts_pins_ff,  nxt_sts_pins;
  logic [7:0]             en_main_ff,   nxt_en_main;
  logic [7:0]             en_pins_ff,   nxt_en_pins;
  logic [CFG_WIDTH-1:0]   cfg_ff,       nxt_cfg;
  logic [NUM_LOCK-1:0]    lock_ff,      nxt_lock;
  logic [NUM_LOCK-1:0]    latch_ff,     nxt_latch;
  logic [NUM_LOCK-1:0]    oe_ff,        nxt_oe;
  logic [NUM_LOCK-1:0]    pp_ff,        nxt_pp;
  logic [31:0]            prdata_ff,    nxt_prdata;

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[9:2] == idx);
  endfunction

  wire  [9:0] a        = apb_req.paddr;
  wire        setup    = apb_req.psel && !apb_req.penable;
  wire        access   = apb_req.psel && apb_req.penable;
  wire        wr       = access && apb_req.pwrite && apb_req.pstrb[0];
  wire  [7:0] wd       = apb_req.pwdata[7:0];
  wire  [7:0] widx     = a[9:2];

  // Bank select is not part of the decode for these offsets
  wire hit_sts_main = hit(a, IDX_WAKE_STATUS_MAIN);
  wire hit_sts_pins = hit(a, IDX_WAKE_STATUS_PINS);
  wire hit_en_main  = hit(a, IDX_WAKE_ENABLE_MAIN);
  wire hit_en_pins  = hit(a, IDX_WAKE_ENABLE_PINS);
  wire hit_cfg      = hit(a, IDX_WAKE_CONFIGURATION);
  wire hit_bd_latch = hit(a, IDX_STANDBY_BIDIR_OUT_LATCH);
  wire hit_bd_in    = hit(a, IDX_STANDBY_BIDIR_IN_LEVEL);
  wire hit_oo_latch = hit(a, IDX_STANDBY_OUTONLY_LATCH);
  wire hit_mx_in    = hit(a, IDX_STANDBY_MIXED_IN_LEVEL);
  wire hit_clr_main = hit(a, IDX_WAKE_CLEAR_MAIN);
  wire hit_clr_pins = hit(a, IDX_WAKE_CLEAR_PINS);
  wire hit_lock     = hit(a, IDX_PIN_CONFIG_LOCK);
  wire hit_oe       = hit(a, IDX_PIN_OUTPUT_ENABLE);
  wire hit_pp       = hit(a, IDX_PIN_PUSH_PULL);
  // Reserved holes answer with zero data and no error
  wire hit_rsvd     = (a[1:0] == 2'b00) &&
                      (((widx >= IDX_RSVD_LO_FIRST) && (widx <= IDX_RSVD_LO_LAST)) ||
                       ((widx >= IDX_RSVD_HI_FIRST) && (widx <= IDX_RSVD_HI_LAST)));
  wire mapped       = hit_sts_main | hit_sts_pins | hit_en_main | hit_en_pins |
                      hit_cfg | hit_bd_latch | hit_bd_in | hit_oo_latch |
                      hit_mx_in | hit_clr_main | hit_clr_pins | hit_lock |
                      hit_oe | hit_pp | hit_rsvd;

  // ************************************************************
  // Live pin levels
  // ************************************************************
  // Raw pin levels, independent of latch and configuration
  wire [7:0] lvl_bidir = {standby_input_pins_hi, standby_bidir_pins_i};
  wire [7:0] lvl_mixed = {4'h0, standby_input_pins_lo, standby_output_pins_i};

  // ************************************************************
  // Read mux, sampled in the setup phase
  // ************************************************************
  wire [7:0] rd_byte =
      hit_sts_main ? sts_main_ff :
      hit_sts_pins ? sts_pins_ff :
      hit_en_main  ? en_main_ff  :
      hit_en_pins  ? en_pins_ff  :
      hit_cfg      ? {4'h0, cfg_ff} :
      hit_bd_latch ? {2'b00, latch_ff[NUM_BIDIR-1:0]} :
      hit_bd_in    ? lvl_bidir :
      hit_oo_latch ? {6'h00, latch_ff[NUM_LOCK-1:LOCK_OUTONLY_LSB]} :
      hit_mx_in    ? lvl_mixed :
      hit_lock     ? lock_ff :
      hit_oe       ? oe_ff :
      hit_pp       ? pp_ff : RST_ZERO_BYTE;

  assign nxt_prdata = setup ? {24'h00_0000, rd_byte} : prdata_ff;

  // ************************************************************
  // Wake status: set wins over clear
  // ************************************************************
  wire [7:0] clr_main = (wr && hit_clr_main) ? wd : 8'h00;
  wire [7:0] clr_pins = (wr && hit_clr_pins) ? wd : 8'h00;
  assign nxt_sts_main = (sts_main_ff & ~clr_main) | wake_event_main;
  assign nxt_sts_pins = (sts_pins_ff & ~clr_pins) | wake_event_pins;

  // ************************************************************
  // Wake enables and configuration
  // ************************************************************
  assign nxt_en_main = (wr && hit_en_main) ? wd : en_main_ff;
  assign nxt_en_pins = (wr && hit_en_pins) ? wd : en_pins_ff;
  assign nxt_cfg     = (wr && hit_cfg) ? wd[CFG_WIDTH-1:0] : cfg_ff;

  // ************************************************************
  // Configuration lock: set-only
  // ************************************************************
  assign nxt_lock = (wr && hit_lock) ? (lock_ff | wd) : lock_ff;

  // ************************************************************
  // Per-pin latch, enable and drive type
  // ************************************************************
  wire [NUM_LOCK-1:0] latch_wval = {wd[NUM_OUTONLY-1:0], wd[NUM_BIDIR-1:0]};
  wire [NUM_LOCK-1:0] latch_wsel = {{NUM_OUTONLY{wr && hit_oo_latch}},
                                    {NUM_BIDIR{wr && hit_bd_latch}}};
  wire [NUM_LOCK-1:0] latch_dflt = {RST_OUTONLY_LATCH, RST_BIDIR_LATCH};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LOCK; gi++)
    begin : g_pin
      // Main reset reloads only unlocked bits
      assign nxt_latch[gi] = lock_ff[gi]   ? latch_ff[gi]   :
                             main_reset    ? latch_dflt[gi] :
                             latch_wsel[gi] ? latch_wval[gi] : latch_ff[gi];
      assign nxt_oe[gi] = (!lock_ff[gi] && wr && hit_oe) ? wd[gi] : oe_ff[gi];
      assign nxt_pp[gi] = (!lock_ff[gi] && wr && hit_pp) ? wd[gi] : pp_ff[gi];
    end
  endgenerate

  // ************************************************************
  // Registers
  // ************************************************************
  // Standby power-up reset clears locks and loads defaults
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sts_main_ff <= RST_ZERO_BYTE;
      sts_pins_ff <= RST_ZERO_BYTE;
      en_main_ff  <= RST_ZERO_BYTE;
      en_pins_ff  <= RST_ZERO_BYTE;
      cfg_ff      <= RST_ZERO_BYTE[CFG_WIDTH-1:0];
      lock_ff     <= RST_ZERO_BYTE;
      latch_ff    <= {RST_OUTONLY_LATCH, RST_BIDIR_LATCH};
      oe_ff       <= {{NUM_OUTONLY{1'b1}}, {NUM_BIDIR{1'b0}}};
      pp_ff       <= RST_ZERO_BYTE;
      prdata_ff   <= RD_ZERO;
    end
    else
    begin
      sts_main_ff <= nxt_sts_main;
      sts_pins_ff <= nxt_sts_pins;
      en_main_ff  <= nxt_en_main;
      en_pins_ff  <= nxt_en_pins;
      cfg_ff      <= nxt_cfg;
      lock_ff     <= nxt_lock;
      latch_ff    <= nxt_latch;
      oe_ff       <= nxt_oe;
      pp_ff       <= nxt_pp;
      prdata_ff   <= nxt_prdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Zero wait state slave; unmapped addresses answer with an error
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access && !mapped;
  assign apb_rsp.prdata  = prdata_ff;

  // Open-drain drives only low; push-pull drives both levels
  wire [NUM_LOCK-1:0] drive_en = oe_ff & (pp_ff | ~latch_ff);
  assign standby_bidir_pins_o   = latch_ff[NUM_BIDIR-1:0];
  assign standby_bidir_pins_oe  = drive_en[NUM_BIDIR-1:0];
  assign standby_output_pins_o  = latch_ff[NUM_LOCK-1:LOCK_OUTONLY_LSB];
  assign standby_output_pins_oe = drive_en[NUM_LOCK-1:LOCK_OUTONLY_LSB];

  // Wake request while any enabled flag stands
  assign wake_irq = |({sts_main_ff, sts_pins_ff} & {en_main_ff, en_pins_ff});
  assign power_button_s3_en = cfg_ff[CFG_PB_S3_BIT];
  assign swap_kbc_inputs    = cfg_ff[CFG_SWAP_KBC_BIT];
  assign config_bank_sel    = cfg_ff[CFG_BANK_MSB:CFG_BANK_LSB];

  // ************************************************************
  // Assertions
  // ************************************************************
  // Level read at setup
  AST_BIDIR_IN_LIVE: assert property (@(posedge clk) disable iff (rst)
    (setup && hit_bd_in) |=> (apb_rsp.prdata[7:0] == $past(lvl_bidir)))
    else $error("bidir level read mismatch");

  // Level writes change nothing
  AST_IN_LEVEL_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
    (wr && (hit_bd_in || hit_mx_in) && !main_reset) |=>
      ($stable(latch_ff) && $stable(lock_ff) && $stable(cfg_ff)))
    else $error("input-level write changed state");

  // Main reset reloads free out-only bits
  AST_MAIN_RESET_LOAD: assert property (@(posedge clk) disable iff (rst)
    main_reset |=> ((latch_ff[7:6] & ~$past(lock_ff[7:6])) ==
                    (RST_OUTONLY_LATCH & ~$past(lock_ff[7:6]))))
    else $error("out-only latch not reloaded");

  // Locked bit survives main reset
  AST_MAIN_RESET_KEEPS: assert property (@(posedge clk) disable iff (rst)
    (main_reset && lock_ff[7]) |=> $stable(latch_ff[7]))
    else $error("locked out-only bit reloaded");

  // Standby reset default
  AST_OUTONLY_RESET: assert property (@(posedge clk)
    rst |=> (latch_ff[7:6] == RST_OUTONLY_LATCH))
    else $error("out-only latch reset value wrong");

  // Pins follow a free latch write
  AST_OUT_PIN_DRIVE: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_oo_latch && !main_reset && (lock_ff[7:6] == 2'b00)) |=>
      (standby_output_pins_o == $past(wd[1:0])))
    else $error("output pin differs from written latch");

  // Locked bit ignores writes
  AST_LOCK_BLOCKS_WRITE: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_bd_latch && lock_ff[0]) |=> $stable(latch_ff[0]))
    else $error("locked latch bit changed");

  // Free bit stores writes
  AST_WRITE_STORES: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_oo_latch && !lock_ff[6] && !main_reset) |=> (latch_ff[6] == $past(wd[0])))
    else $error("unlocked latch write lost");

  // Bidir latch readback
  AST_LATCH_READBACK: assert property (@(posedge clk) disable iff (rst)
    (setup && hit_bd_latch) |=> (apb_rsp.prdata[7:0] == {2'b00, $past(latch_ff[5:0])}))
    else $error("latch readback mismatch");

  // Out-only latch readback
  AST_OUTONLY_READBACK: assert property (@(posedge clk) disable iff (rst)
    (setup && hit_oo_latch) |=> (apb_rsp.prdata[1:0] == $past(latch_ff[7:6])))
    else $error("out-only readback mismatch");

  // Mixed level read at setup
  AST_MIXED_IN_LIVE: assert property (@(posedge clk) disable iff (rst)
    (setup && hit_mx_in) |=> (apb_rsp.prdata[7:0] ==
      {4'h0, $past(standby_input_pins_lo), $past(standby_output_pins_i)}))
    else $error("mixed level read mismatch");

  // Reserved holes give no error
  AST_RSVD_NO_ERROR: assert property (@(posedge clk) disable iff (rst)
    (access && hit_rsvd) |-> !apb_rsp.pslverr)
    else $error("reserved index answered with error");

  // Flag holds until cleared
  AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (rst)
    wake_event_main[0] |=> sts_main_ff[0] [*2] or (sts_main_ff[0] ##1 $past(clr_main[0])))
    else $error("wake flag not held");

  // Every event sets its flag
  AST_EVENT_SETS_MAIN: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ((sts_main_ff & $past(wake_event_main)) == $past(wake_event_main)))
    else $error("main wake event lost");

  // Every pin event sets its flag
  AST_EVENT_SETS_PINS: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ((sts_pins_ff & $past(wake_event_pins)) == $past(wake_event_pins)))
    else $error("pin wake event lost");

  // Clear drops quiet flags
  AST_CLEAR_MAIN: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_clr_main) |=> ((sts_main_ff & $past(wd & ~wake_event_main)) == 8'h00))
    else $error("main wake flag not cleared");

  // Clear drops quiet pin flags
  AST_CLEAR_PINS: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_clr_pins) |=> ((sts_pins_ff & $past(wd & ~wake_event_pins)) == 8'h00))
    else $error("pin wake flag not cleared");

  // Status writes drop nothing
  AST_STATUS_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_sts_main) |=> ((sts_main_ff & $past(sts_main_ff)) == $past(sts_main_ff)))
    else $error("status write dropped a flag");

  // Main enables store the byte
  AST_ENABLE_MAIN: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_en_main) |=> (en_main_ff == $past(wd)))
    else $error("main enable write lost");

  // Pin enables store the byte
  AST_ENABLE_PINS: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_en_pins) |=> (en_pins_ff == $past(wd)))
    else $error("pin enable write lost");

  // Configuration fields reach outputs
  AST_CFG_FIELDS: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_cfg) |=> ((config_bank_sel == $past(wd[CFG_BANK_MSB:CFG_BANK_LSB])) &&
      (swap_kbc_inputs == $past(wd[CFG_SWAP_KBC_BIT])) &&
      (power_button_s3_en == $past(wd[CFG_PB_S3_BIT]))))
    else $error("configuration field mismatch");

  // Lock bits never fall outside standby reset
  AST_LOCK_SET_ONLY: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ((lock_ff & $past(lock_ff)) == $past(lock_ff)))
    else $error("lock bit cleared without standby reset");

  // Written lock bits take hold
  AST_LOCK_SETS: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_lock) |=> ((lock_ff & $past(wd)) == $past(wd)))
    else $error("lock bit not set");

  // Standby reset bidir default
  AST_BIDIR_RESET: assert property (@(posedge clk)
    rst |=> (latch_ff[5:0] == RST_BIDIR_LATCH))
    else $error("bidir latch reset value wrong");

  // Main reset reloads free bidir bit
  AST_BIDIR_MAIN_RESET: assert property (@(posedge clk) disable iff (rst)
    (main_reset && !lock_ff[5]) |=> (latch_ff[5] == RST_BIDIR_LATCH[5]))
    else $error("bidir latch not reloaded");

  // Reserved bits read zero
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    (setup && (hit_oo_latch || hit_rsvd)) |=> (apb_rsp.prdata[7:2] == 6'h00))
    else $error("reserved bits read nonzero");

  // Upper data bits stay zero
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
    access |-> (apb_rsp.prdata[31:8] == 24'h00_0000))
    else $error("upper read data nonzero");

endmodule

//--- test/sgw_board_model.sv
// Board model: resolves standby pin line levels from all drivers and pull-ups
`timescale 1ns/1ps
module sgw_board_model
  import sgw_pkg::*;
(
  // Device side drivers
  input  wire logic [sgw_pkg::NUM_BIDIR-1:0] dev_bidir_val,
  input  wire logic [sgw_pkg::NUM_BIDIR-1:0] dev_bidir_en,
  input  wire logic [1:0]                    dev_out_val,
  input  wire logic [1:0]                    dev_out_en,
  // Board side drivers on bidirectional lines
  input  wire logic [sgw_pkg::NUM_BIDIR-1:0] brd_en,
  input  wire logic [sgw_pkg::NUM_BIDIR-1:0] brd_val,
  // Resolved line levels
  output logic [sgw_pkg::NUM_BIDIR-1:0]      line_bidir,
  output logic [1:0]                         line_out
);
  // Device driver first, then board, else the pull-up pulls high
  always_comb
  begin
    for (int i = 0; i < NUM_BIDIR; i++)
      line_bidir[i] = dev_bidir_en[i] ? dev_bidir_val[i] : (brd_en[i] ? brd_val[i] : 1'b1);
    line_out = (dev_out_en & dev_out_val) | ~dev_out_en;
  end
endmodule

//--- test/sgw_standby_gpio_wake_regs_tb.sv
// Testbench: register, pin and wake checks over the host bus
`timescale 1ns/1ps
module sgw_standby_gpio_wake_regs_tb;
  import sgw_pkg::*;
  logic         clk, rst, main_reset, wake_irq, pb_s3, swap_kbc;
  sgw_apb_req_t apb_req;
  sgw_apb_rsp_t apb_rsp;
  logic [5:0]   bid_o, bid_oe, bid_lvl, brd_en, brd_val;
  logic [1:0]   out_o, out_oe, out_lvl, in_hi, in_lo, bank;
  logic [7:0]   ev_main, ev_pins;
  int           mismatches, checks_done;

  // Design and board
  sgw_standby_gpio_wake_regs #(.ADDR_W(10)) DUT (.clk(clk), .rst(rst), .main_reset(main_reset),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .standby_bidir_pins_i(bid_lvl),
    .standby_bidir_pins_o(bid_o), .standby_bidir_pins_oe(bid_oe),
    .standby_output_pins_i(out_lvl), .standby_output_pins_o(out_o),
    .standby_output_pins_oe(out_oe), .standby_input_pins_hi(in_hi),
    .standby_input_pins_lo(in_lo), .wake_event_main(ev_main), .wake_event_pins(ev_pins),
    .wake_irq(wake_irq), .power_button_s3_en(pb_s3), .swap_kbc_inputs(swap_kbc),
    .config_bank_sel(bank));
  sgw_board_model board (.dev_bidir_val(bid_o), .dev_bidir_en(bid_oe), .dev_out_val(out_o),
    .dev_out_en(out_oe), .brd_en(brd_en), .brd_val(brd_val), .line_bidir(bid_lvl),
    .line_out(out_lvl));

  // Clock at 100 ns
  always #50 clk = ~clk;

  // ************************************************************
  // Compare, bus and closing tasks
  // ************************************************************
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: register value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: pin or flag value %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdat, output logic err);
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {idx, 2'b00};
    apb_req.pwdata  <= {24'h00_0000, wd};
    apb_req.pstrb   <= 4'hF;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    err  = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, idx, wd, r, e);
    chk_pin({7'h00, e}, 8'h00);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, idx, 8'h00, r, e);
    chk_reg(r, {24'h00_0000, exp});
    chk_pin({7'h00, e}, 8'h00);
  endtask

  // Unmapped place: error response and zero data
  task automatic bad(input logic dir, input logic [7:0] idx);
    logic [31:0] r;
    logic        e;
    xfer(dir, idx, 8'hFF, r, e);
    chk_pin({7'h00, e}, 8'h01);
    chk_reg(r, 32'h0000_0000);
  endtask

  task automatic end_sim();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    clk = 0; rst = 1; main_reset = 0; apb_req = '0; ev_main = 0; ev_pins = 0;
    brd_en = 6'h3F; brd_val = 6'h15; in_hi = 2'b10; in_lo = 2'b01;
    mismatches = 0; checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08, 8'h3F);
    rd(8'h0A, 8'h03);
    for (int i = 0; i < 5; i++) rd(i[7:0], 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h09, 8'h95);
    rd(8'h08, 8'h3F);
    rd(8'h0B, 8'h07);
    wr(8'h09, 8'h00);
    wr(8'h0B, 8'hFF);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h08, 8'h3F);
    rd(8'h09, 8'h95);
    // Push-pull drive of every pin
    brd_en <= 6'h00;
    wr(8'h24, 8'hFF);
    wr(8'h23, 8'hFF);
    wr(8'h08, 8'hEA);
    wr(8'h0A, 8'h01);
    @(negedge clk);
    chk_pin({2'b00, bid_o}, 8'h2A);
    chk_pin({2'b00, bid_oe}, 8'h3F);
    chk_pin({6'h00, out_o}, 8'h01);
    rd(8'h08, 8'h2A);
    rd(8'h09, 8'hAA);
    rd(8'h0B, 8'h05);
    // Open drain: only a low latch bit drives
    wr(8'h24, 8'h00);
    @(negedge clk);
    chk_pin({6'h00, out_oe}, 8'h02);
    // Lock freezes latch bits
    wr(8'h0A, 8'h00);
    wr(8'h22, 8'h81);
    wr(8'h08, 8'h3F);
    rd(8'h08, 8'h3E);
    wr(8'h0A, 8'h03);
    rd(8'h0A, 8'h01);
    wr(8'h22, 8'h00);
    rd(8'h22, 8'h81);
    wr(8'h08, 8'h00);
    wr(8'h0A, 8'h00);
    @(posedge clk);
    main_reset <= 1'b1;
    @(posedge clk);
    main_reset <= 1'b0;
    rd(8'h08, 8'h3E);
    rd(8'h0A, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(8'h22, 8'h00);
    rd(8'h0A, 8'h03);
    // Wake flags, enables and clears
    @(posedge clk);
    ev_main <= 8'hA5;
    ev_pins <= 8'h3C;
    @(posedge clk);
    ev_main <= 8'h00;
    ev_pins <= 8'h00;
    rd(8'h00, 8'hA5);
    rd(8'h01, 8'h3C);
    chk_pin({7'h00, wake_irq}, 8'h00);
    wr(8'h02, 8'h01);
    @(negedge clk);
    chk_pin({7'h00, wake_irq}, 8'h01);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'hA5);
    wr(8'h20, 8'hFF);
    rd(8'h00, 8'h00);
    chk_pin({7'h00, wake_irq}, 8'h00);
    // Event during a clear of the same flag: the event wins
    ev_main <= 8'h02;
    wr(8'h20, 8'h02);
    ev_main <= 8'h00;
    rd(8'h00, 8'h02);
    wr(8'h03, 8'h04);
    @(negedge clk);
    chk_pin({7'h00, wake_irq}, 8'h01);
    wr(8'h21, 8'h04);
    rd(8'h01, 8'h38);
    chk_pin({7'h00, wake_irq}, 8'h00);
    // Configuration and bank independence
    wr(8'h04, 8'hFD);
    @(negedge clk);
    chk_pin({4'h0, pb_s3, swap_kbc, bank}, 8'h0D);
    rd(8'h04, 8'h0D);
    rd(8'h0A, 8'h03);
    rd(8'h03, 8'h04);
    wr(8'h04, 8'h04);
    @(negedge clk);
    chk_pin({4'h0, pb_s3, swap_kbc, bank}, 8'h04);
    bad(1'b0, 8'h40);
    bad(1'b1, 8'h40);
    end_sim();
  end
endmodule
